// ==== hdl/pll_pkg.sv ====
/*
 * Constants, register map and state codes shared by the clock generator
 * control files.
 * Assumes: a 32-bit classic Wishbone slave, with 8-bit registers in the low lane.
 */
package pll_pkg;

  // ----------------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [5:0] IDX_CTRL = 6'h3a;  // pll_control_reg
  localparam logic [5:0] IDX_BW   = 6'h3b;  // bandwidth control
  localparam logic [5:0] IDX_MULH = 6'h3c;  // multiplier_high_reg
  localparam logic [5:0] IDX_MULL = 6'h3d;  // multiplier_low_reg
  localparam logic [5:0] IDX_RDIV = 6'h3e;  // ref_divider_reg

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_IE_BIT  = 7;
  localparam int CTRL_LF_BIT  = 6;
  localparam int CTRL_ON_BIT  = 5;
  localparam int CTRL_BS_BIT  = 4;
  localparam int CTRL_PRE_LSB = 2;
  localparam int BW_AUTO_BIT  = 7;
  localparam int BW_LOCK_BIT  = 6;
  localparam int BW_TRK_BIT   = 5;

  localparam logic       ON_RST  = 1'h1;
  localparam logic [1:0] PRE_RST = 2'h2;

  localparam int N_W = 12;  // Multiplier width
  localparam int R_W = 4;   // Reference divider width

  // ----------------------------------------------------------------------
  // Frequency comparison window, in reference pulses, and tolerances, in feedback pulses
  // ----------------------------------------------------------------------
  localparam logic [7:0] WIN_LEN  = 8'h10;
  localparam logic [7:0] TRK_TOL  = 8'h02;
  localparam logic [7:0] UNT_TOL  = 8'h04;
  localparam logic [7:0] LOCK_TOL = 8'h01;
  localparam logic [7:0] UNL_TOL  = 8'h03;

  // Edges of the crystal, and of the VCO while the PLL runs, waited for on a source change
  localparam logic [1:0] SWITCH_EDGES = 2'h3;

  typedef enum logic [0:0] {
    ST_RUN    = 1'b0,
    ST_SWITCH = 1'b1
  } sel_state_t;

endpackage

// ==== hdl/div_if.sv ====
/*
 * Carrier between the controller and one modulo divider.
 * Assumes: both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface div_if;
  logic        in_pulse;
  logic [11:0] modulus;
  logic        out_pulse;
  modport ctl (output in_pulse, output modulus, input out_pulse);
  modport div (input in_pulse, input modulus, output out_pulse);
endinterface
`default_nettype wire

// ==== hdl/mod_divider.sv ====
/*
 * Modulo divider: one output pulse for every modulus input pulses.
 * Assumes: input pulses last one clock; same clock as the controller.
 */
`timescale 1ns/100ps
`default_nettype none
module mod_divider (
  input  wire logic clk_i,
  input  wire logic rst_i,
  div_if.div        d
);

  typedef struct packed {
    logic [11:0] cnt;
    logic        out;
  } div_state_t;

  div_state_t  q;
  div_state_t  n;
  logic [11:0] mod_eff;

  // ----------------------------------------------------------------------
  // Count input pulses, a zero modulus acting as one
  // ----------------------------------------------------------------------
  always_comb begin
    mod_eff = (d.modulus == 12'h000) ? 12'h001 : d.modulus;
    n       = q;
    n.out   = 1'b0;
    if (d.in_pulse) begin
      if (q.cnt >= mod_eff - 12'h001) begin
        n.cnt = 12'h000;
        n.out = 1'b1;
      end else begin
        n.cnt = q.cnt + 12'h001;
      end
    end
  end

  // Register the state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign d.out_pulse = q.out;

endmodule
`default_nettype wire

// ==== hdl/pll_clock_generator_control.sv ====
/*
 * Clock generator control: crystal gating, reference and feedback
 * dividers, phase and lock detection, filter mode, base clock selection
 * and the register file over classic Wishbone.
 * Assumes: the crystal and the analog oscillator arrive as pins, sampled
 * at a clock well above their rate; the analog loop filter acts on the
 * pump outputs.
 */
// Decided for this implementation: the placing of the registers and register access over Wishbone.
// Function
// - Base clock is crystal or PLL, halved.
// - Oscillator runs only while enable is asserted.
// - Reference clock buffers the crystal clock.
// - Reference divider divides by R.
// - Feedback divides VCO by two-power P, then N.
// - Phase detector emits up or down pulses.
// - Lock detector compares frequencies per reference window.
// - Acquisition mode reads tracking flag cleared.
// - Tracking mode when flag set or not acquiring.
// - Auto bit lets detector switch modes itself.
// - Auto tracking flag follows track/untrack tolerances.
// - Settled flag follows lock/unlock tolerances.
// - Settled flag toggle raises interrupt when enabled.
// - Zero R or N behaves as one.
// - Source change holds output, waits three crystal edges, and three VCO edges while the PLL runs.
// - VCO select and PLL power interlocked.
`timescale 1ns/100ps
`default_nettype none
module pll_clock_generator_control (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        xtal_in_i,
  input  wire logic        oscillator_enable_i,
  input  wire logic        vco_clock_i,
  output logic             xtal_out_o,
  output logic             crystal_clock_o,
  output logic             reference_clock_o,
  output logic             pll_enable_o,
  output logic             divided_reference_o,
  output logic             vco_feedback_clock_o,
  output logic             pump_up_o,
  output logic             pump_down_o,
  output logic             acq_mode_o,
  output logic             base_clock_out_o,
  output logic             irq_o
);

  typedef struct packed {
    logic                  x1, x2, x3;      // Crystal synchroniser and edge stage
    logic                  v1, v2, v3;      // VCO synchroniser and edge stage
    logic                  e1, e2;          // Oscillator enable synchroniser
    logic                  ack;
    logic [7:0]            rdat;
    logic                  ie;              // lock_change_irq_enable
    logic                  lf;              // Lock change flag
    logic                  pll_on;
    logic                  bsel;            // base_select_bit
    logic [1:0]            pre;
    logic                  autobw;
    logic                  lock;
    logic                  trk;             // tracking_state_flag
    logic [pll_pkg::N_W-1:0] mul;
    logic [pll_pkg::R_W-1:0] rdiv;
    logic [2:0]            pcnt;            // Power-of-two prescaler
    logic [7:0]            wref;            // Window position
    logic [7:0]            wfb;             // Feedback pulses in window
    logic                  up, dn;
    pll_pkg::sel_state_t   sw;
    logic                  active;          // Source in use: 1 = PLL
    logic [1:0]            xe, ve;          // Edges seen while switching
    logic                  base;
    logic                  xout, xclk, rclk, pen, rdo, fbo, tracking_state_flag, irq;
  } top_state_t;

  top_state_t q;
  top_state_t n;
  div_if      rdv ();
  div_if      fdv ();

  logic       x_edge;
  logic       v_edge;
  logic       pll_run;
  logic       req;
  logic [5:0] idx;
  logic       win_end;
  logic [7:0] diff;
  logic       p_tick;
  logic [2:0] p_mask;
  logic       new_on;
  logic       new_bs;

  // ----------------------------------------------------------------------
  // Reference and feedback dividers
  // ----------------------------------------------------------------------
  mod_divider ref_div (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d     (rdv.div)
  );

  mod_divider fb_div (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d     (fdv.div)
  );

  // Divider inputs: gated crystal edges and prescaled VCO edges
  assign rdv.in_pulse = x_edge && pll_run;
  assign rdv.modulus  = {{(12 - pll_pkg::R_W){1'b0}}, q.rdiv};
  assign fdv.in_pulse = p_tick;
  assign fdv.modulus  = q.mul;

  // Edge and decode helpers
  assign x_edge  = q.x2 && !q.x3 && q.e2;
  assign v_edge  = q.v2 && !q.v3 && pll_run;
  assign pll_run = q.pll_on && q.e2;
  assign p_mask  = 3'(({1'b0, 2'h0} | 3'h1) << q.pre) - 3'h1;
  assign p_tick  = v_edge && ((q.pcnt & p_mask) == p_mask);
  assign req     = cyc_i && stb_i && !q.ack;
  assign idx     = adr_i[7:2];
  assign win_end = rdv.out_pulse && (q.wref == pll_pkg::WIN_LEN - 8'h01);
  assign diff    = (q.wfb >= pll_pkg::WIN_LEN) ? q.wfb - pll_pkg::WIN_LEN
                                                : pll_pkg::WIN_LEN - q.wfb;
  assign new_on  = dat_i[pll_pkg::CTRL_ON_BIT];
  assign new_bs  = dat_i[pll_pkg::CTRL_BS_BIT];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    n = q;

    // Pin synchronisers
    n.x1 = xtal_in_i;
    n.x2 = q.x1;
    n.x3 = q.x2;
    n.v1 = vco_clock_i;
    n.v2 = q.v1;
    n.v3 = q.v2;
    n.e1 = oscillator_enable_i;
    n.e2 = q.e1;

    // Wishbone answer one cycle after the request, dropped after one
    n.ack  = req;
    n.rdat = 8'h00;
    if (req && !we_i) begin
      case (idx)
        pll_pkg::IDX_CTRL: n.rdat = {q.ie, q.lf, q.pll_on, q.bsel, q.pre, 2'h0};
        pll_pkg::IDX_BW:   n.rdat = {q.autobw, q.lock, q.trk, 5'h00};
        pll_pkg::IDX_MULH: n.rdat = {4'h0, q.mul[11:8]};
        pll_pkg::IDX_MULL: n.rdat = q.mul[7:0];
        pll_pkg::IDX_RDIV: n.rdat = {4'h0, q.rdiv};
        default:           n.rdat = 8'h00;
      endcase
      if (idx == pll_pkg::IDX_CTRL) begin
        n.lf = 1'b0;  // Reading control clears the lock change flag
      end
    end

    // Register writes
    if (req && we_i && sel_i[0]) begin
      case (idx)
        pll_pkg::IDX_CTRL: begin
          n.ie  = dat_i[pll_pkg::CTRL_IE_BIT];
          n.pre = dat_i[pll_pkg::CTRL_PRE_LSB +: 2];
          // Power and VCO select may not change together or out of order
          if (!((new_on != q.pll_on) && (new_bs != q.bsel))) begin
            if (!(q.bsel && !new_on)) begin
              n.pll_on = new_on;
            end
            if (!(new_bs && !q.pll_on)) begin
              n.bsel = new_bs;
            end
          end
        end
        pll_pkg::IDX_BW: begin
          n.autobw = dat_i[pll_pkg::BW_AUTO_BIT];
          if (!q.autobw) begin
            n.trk = dat_i[pll_pkg::BW_TRK_BIT];
          end
        end
        pll_pkg::IDX_MULH: n.mul[11:8] = dat_i[3:0];
        pll_pkg::IDX_MULL: n.mul[7:0]  = dat_i[7:0];
        pll_pkg::IDX_RDIV: n.rdiv      = dat_i[pll_pkg::R_W-1:0];
        default:           n.rdiv      = q.rdiv;
      endcase
    end

    // Power-of-two prescaler on VCO edges
    if (v_edge) begin
      n.pcnt = q.pcnt + 3'h1;
    end

    // Phase detector: both sides seen cancels the correction
    n.up = q.up || rdv.out_pulse;
    n.dn = q.dn || fdv.out_pulse;
    if (n.up && n.dn) begin
      n.up = 1'b0;
      n.dn = 1'b0;
    end

    // Lock detector: feedback pulses per window of reference pulses
    if (fdv.out_pulse && q.wfb != 8'hff) begin
      n.wfb = q.wfb + 8'h01;
    end
    if (rdv.out_pulse) begin
      n.wref = q.wref + 8'h01;
    end
    if (win_end) begin
      n.wref = 8'h00;
      n.wfb  = {7'h00, fdv.out_pulse};
      if (diff <= pll_pkg::LOCK_TOL) begin
        n.lock = 1'b1;
      end else if (diff > pll_pkg::UNL_TOL) begin
        n.lock = 1'b0;
      end
      if (q.autobw) begin
        if (diff <= pll_pkg::TRK_TOL) begin
          n.trk = 1'b1;
        end else if (diff > pll_pkg::UNT_TOL) begin
          n.trk = 1'b0;
        end
      end
    end
    if (!pll_run) begin
      n.lock = 1'b0;
      n.wref = 8'h00;
      n.wfb  = 8'h00;
      n.up   = 1'b0;
      n.dn   = 1'b0;
      if (q.autobw) begin
        n.trk = 1'b0;
      end
    end

    // Any toggle of the settled flag sets the sticky flag; set wins
    if (n.lock != q.lock) begin
      n.lf = 1'b1;
    end

    // Base clock selector with transition control
    case (q.sw)
      pll_pkg::ST_RUN: begin
        if (q.bsel != q.active) begin
          n.sw = pll_pkg::ST_SWITCH;
          n.xe = 2'h0;
          n.ve = 2'h0;
        end else if (q.active ? v_edge : x_edge) begin
          n.base = !q.base;
        end
      end
      pll_pkg::ST_SWITCH: begin
        // Output held static meanwhile
        if (x_edge && q.xe != pll_pkg::SWITCH_EDGES) begin
          n.xe = q.xe + 2'h1;
        end
        if (v_edge && q.ve != pll_pkg::SWITCH_EDGES) begin
          n.ve = q.ve + 2'h1;
        end
        if (q.xe == pll_pkg::SWITCH_EDGES &&
            (q.ve == pll_pkg::SWITCH_EDGES || !pll_run)) begin
          n.active = q.bsel;
          n.sw     = pll_pkg::ST_RUN;
        end
      end
      default: n.sw = pll_pkg::ST_RUN;
    endcase

    // Registered outputs
    n.xout = q.e2 && !q.x2;
    n.xclk = q.e2 && q.x2;
    n.rclk = q.e2 && q.x2;
    n.pen  = pll_run;
    n.rdo  = rdv.out_pulse;
    n.fbo  = fdv.out_pulse;
    n.tracking_state_flag  = !n.trk;
    n.irq  = n.lf && n.ie;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q        <= '0;
      q.pll_on <= pll_pkg::ON_RST;
      q.pre    <= pll_pkg::PRE_RST;
      q.tracking_state_flag    <= 1'b1;
      q.sw     <= pll_pkg::ST_RUN;
    end else begin
      q <= n;
    end
  end

  // Output connections
  assign dat_o                = {24'h000000, q.rdat};
  assign ack_o                = q.ack;
  assign xtal_out_o           = q.xout;
  assign crystal_clock_o      = q.xclk;
  assign reference_clock_o    = q.rclk;
  assign pll_enable_o         = q.pen;
  assign divided_reference_o  = q.rdo;
  assign vco_feedback_clock_o = q.fbo;
  assign pump_up_o            = q.up;
  assign pump_down_o          = q.dn;
  assign acq_mode_o           = q.tracking_state_flag;
  assign base_clock_out_o     = q.base;
  assign irq_o                = q.irq;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus answers in the next cycle, for one cycle
  AST_ACK_ONE: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
    else $error("ack not given for exactly one cycle");

  AST_OSC_OFF: assert property (!q.e2 |=> !xtal_out_o && !crystal_clock_o)
    else $error("oscillator output while disabled");

  AST_VCO_NEEDS_ON: assert property (q.bsel |-> q.pll_on)
    else $error("VCO selected while PLL off");

  AST_HOLD_SWITCH: assert property ((q.sw == pll_pkg::ST_SWITCH) |=> $stable(base_clock_out_o))
    else $error("base clock moved during source change");

  AST_ACQ_FLAG: assert property (acq_mode_o |-> !q.trk)
    else $error("acquisition with tracking flag set");

  AST_TRK_MODE: assert property (q.trk |-> !acq_mode_o)
    else $error("tracking flag set but not tracking");

  AST_PFD_CANCEL: assert property ((rdv.out_pulse && fdv.out_pulse) |=> !pump_up_o && !pump_down_o)
    else $error("pump pulse after coincident edges");

  AST_TRK_SET: assert property ((win_end && pll_run && q.autobw && diff <= pll_pkg::TRK_TOL) |=> q.trk)
    else $error("tracking flag not set inside tolerance");

  AST_UNLOCK: assert property ((win_end && diff > pll_pkg::UNL_TOL) |=> !q.lock)
    else $error("settled flag kept outside unlock tolerance");

  AST_IRQ: assert property (($changed(q.lock) && q.ie) |-> irq_o)
    else $error("no interrupt on settled flag toggle");

endmodule
`default_nettype wire

// ==== testbench/clk_source_model.sv ====
/*
 * Far-side stand-in: crystal pin, analog oscillator pin and the
 * oscillator enable from system integration.
 * Assumes: stepped by the bench clock; half periods are in clock cycles.
 */
`timescale 1ns/100ps
`default_nettype none
module clk_source_model (
  input  wire logic       clk_i,
  input  wire logic       en_req_i,
  input  wire logic [3:0] vco_half_i,
  output logic            xtal_o,
  output logic            vco_o,
  output logic            osc_en_o
);
  int xc;
  int vc;

  // ---------------------------------------------------------------
  // Sources
  // ---------------------------------------------------------------
  // Both pins start low with the oscillator disabled
  initial begin
    xtal_o = 1'h0;
    vco_o = 1'h0;
    osc_en_o = 1'h0;
    xc = 0;
    vc = 0;
  end

  // Crystal runs free, eight clocks a period; VCO stands low at half period zero
  always @(posedge clk_i) begin
    osc_en_o <= en_req_i;
    xc <= (xc == 3) ? 0 : xc + 1;
    if (xc == 3) begin
      xtal_o <= ~xtal_o;
    end
    vc <= (vc + 1 >= int'(vco_half_i)) ? 0 : vc + 1;
    if (vco_half_i == 4'h0) begin
      vco_o <= 1'h0;
    end else if (vc + 1 >= int'(vco_half_i)) begin
      vco_o <= ~vco_o;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/pll_clock_generator_control_tb_top.sv ====
/*
 * Self-checking bench for the clock generator control block.
 * Assumes: design assertions live in the design files; crystal pin
 * rises every 8 clocks, VCO pin every 2 x vco_half clocks.
 */
`timescale 1ns/100ps
`default_nettype none
module pll_clock_generator_control_tb_top;
  logic        clk_i;
  logic        rst_i;
  logic [7:0]  adr_i;
  logic [31:0] dat_i;
  logic [3:0]  sel_i;
  logic        we_i;
  logic        cyc_i;
  logic        stb_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        xtal_in_i;
  logic        oscillator_enable_i;
  logic        vco_clock_i;
  logic        xtal_out_o;
  logic        crystal_clock_o;
  logic        reference_clock_o;
  logic        pll_enable_o;
  logic        divided_reference_o;
  logic        vco_feedback_clock_o;
  logic        pump_up_o;
  logic        pump_down_o;
  logic        acq_mode_o;
  logic        base_clock_out_o;
  logic        irq_o;
  logic        en_req;
  logic [3:0]  vco_half;
  logic [7:0]  rd;
  logic [7:0]  v;
  logic [15:0] g;
  logic        pb;
  int          failures;
  int          n_compared;
  int          i;
  int          c;
  int          t;
  int          pv [5] = '{0, 1, 3, 2, 0};
  int          nv [5] = '{0, 3, 5, 1, 257};

  pll_clock_generator_control pll_clock_generator_control_inst (
    .clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i, .stb_i, .dat_o, .ack_o,
    .xtal_in_i, .oscillator_enable_i, .vco_clock_i, .xtal_out_o, .crystal_clock_o,
    .reference_clock_o, .pll_enable_o, .divided_reference_o, .vco_feedback_clock_o,
    .pump_up_o, .pump_down_o, .acq_mode_o, .base_clock_out_o, .irq_o
  );

  clk_source_model clk_source_model_inst (
    .clk_i(clk_i), .en_req_i(en_req), .vco_half_i(vco_half), .xtal_o(xtal_in_i),
    .vco_o(vco_clock_i), .osc_en_o(oscillator_enable_i)
  );

  // ---------------------------------------------------------------
  // Clock, watchdog and verdict
  // ---------------------------------------------------------------
  // 100 ns clock
  initial begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end

  // Cuts a hang short well past the expected run length
  initial begin
    repeat (40000) @(posedge clk_i);
    failures++;
    give_verdict();
  end

  task automatic give_verdict();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Compare, bus and measurement tasks
  // ---------------------------------------------------------------
  task automatic chk_reg(input string what, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic chk_cnt(input string what, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %0d seen %0d", what, e, s);
    end
  endtask

  // One classic cycle; held until ack is sampled high
  task automatic wb(input logic [5:0] idx, input logic w, input logic [7:0] wd,
                    input logic [3:0] s);
    @(posedge clk_i);
    adr_i <= {idx, 2'h0};
    dat_i <= {24'h0, wd};
    we_i <= w;
    sel_i <= s;
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'h1);
    rd = dat_o[7:0];
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    we_i <= 1'h0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    wb(idx, 1'h1, d, 4'h1);
  endtask

  task automatic rdchk(input string what, input logic [5:0] idx, input logic [7:0] e,
                       input logic [7:0] m);
    wb(idx, 1'h0, 8'h0, 4'hf);
    chk_reg(what, e, rd & m);
  endtask

  // First full interval: 0 crystal rises per reference pulse,
  // 1 VCO rises per feedback pulse, 2 clocks per base output change
  task automatic gap(input int kind, output logic [15:0] n);
    int k;
    int w;
    int cnt;
    logic s;
    logic ps;
    logic m;
    k = 0;
    w = 0;
    cnt = 0;
    ps = 1'h1;
    n = '0;
    while (k < 2 && w < 9000) begin
      @(posedge clk_i);
      w++;
      s = (kind == 0) ? xtal_in_i : vco_clock_i;
      m = (kind == 0) ? divided_reference_o : (kind == 1) ? vco_feedback_clock_o :
          (base_clock_out_o !== pb);
      pb = base_clock_out_o;
      if (m === 1'h1) begin
        k++;
        n = cnt[15:0];
        cnt = 0;
      end
      if (kind == 2 || (s && !ps)) begin
        cnt++;
      end
      ps = s;
    end
    if (k < 2) begin
      failures++;
      $display("unexpected interval events expected 2 seen %0d", k);
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {adr_i, dat_i, sel_i, we_i, cyc_i, stb_i} = '0;
    rst_i = 1'h1;
    en_req = 1'h0;
    vco_half = 4'h0;
    failures = 0;
    n_compared = 0;
    pb = 1'h0;
    i = $urandom(32'h015b);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    chk_reg("acq after reset", 8'h1, {7'h0, acq_mode_o});
    rdchk("ctrl reset", pll_pkg::IDX_CTRL, 8'h28, 8'hff);
    rdchk("bw reset", pll_pkg::IDX_BW, 8'h00, 8'hff);
    rdchk("mulh reset", pll_pkg::IDX_MULH, 8'h00, 8'hff);
    rdchk("mull reset", pll_pkg::IDX_MULL, 8'h00, 8'hff);
    rdchk("rdiv reset", pll_pkg::IDX_RDIV, 8'h00, 8'hff);
    wr(6'h00, 8'hff);
    rdchk("unmapped", 6'h00, 8'h00, 8'hff);
    // Random divider values read back through their field masks
    for (i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(pll_pkg::IDX_MULH, v);
      wr(pll_pkg::IDX_MULL, v);
      wr(pll_pkg::IDX_RDIV, v);
      rdchk("mulh", pll_pkg::IDX_MULH, v & 8'h0f, 8'hff);
      rdchk("mull", pll_pkg::IDX_MULL, v, 8'hff);
      rdchk("rdiv", pll_pkg::IDX_RDIV, v & 8'h0f, 8'hff);
    end
    wb(pll_pkg::IDX_MULL, 1'h1, ~v, 4'h0);
    rdchk("mull no lane", pll_pkg::IDX_MULL, v, 8'hff);
    // Crystal path quiet while the enable is low, then running
    repeat (40) @(posedge clk_i);
    c = 0;
    t = 0;
    repeat (100) begin
      @(posedge clk_i);
      c += (crystal_clock_o !== 1'h0 || pll_enable_o !== 1'h0) ? 1 : 0;
    end
    chk_cnt("gated crystal", 16'h0, c[15:0]);
    en_req <= 1'h1;
    repeat (10) @(posedge clk_i);
    c = 0;
    pb = crystal_clock_o;
    repeat (100) begin
      @(posedge clk_i);
      c += (reference_clock_o !== crystal_clock_o || xtal_out_o !== ~crystal_clock_o) ? 1 : 0;
      t += (crystal_clock_o !== pb) ? 1 : 0;
      pb = crystal_clock_o;
    end
    chk_cnt("reference copy", 16'h0, c[15:0]);
    chk_cnt("crystal toggles", 16'd25, t[15:0]);
    // Reference and feedback divider intervals
    vco_half <= 4'h2;
    foreach (nv[i]) begin
      wr(pll_pkg::IDX_RDIV, 8'(pv[i] * 5));
      gap(0, g);
      chk_cnt("ref interval", 16'((pv[i] == 0) ? 1 : pv[i] * 5), g);
      wr(pll_pkg::IDX_CTRL, 8'h20 | 8'(pv[i] << 2));
      wr(pll_pkg::IDX_MULH, 8'(nv[i] >> 8));
      wr(pll_pkg::IDX_MULL, 8'(nv[i]));
      gap(1, g);
      chk_cnt("fb interval", 16'(((nv[i] == 0) ? 1 : nv[i]) << pv[i]), g);
    end
    // Lock acquisition: R = 1, P = 0, N = 2 matches the feedback to the reference
    wr(pll_pkg::IDX_RDIV, 8'h01);
    wr(pll_pkg::IDX_MULH, 8'h00);
    wr(pll_pkg::IDX_MULL, 8'h02);
    vco_half <= 4'h0;
    wr(pll_pkg::IDX_BW, 8'h80);
    repeat (400) @(posedge clk_i);
    wr(pll_pkg::IDX_BW, 8'ha0);
    rdchk("bw auto trk", pll_pkg::IDX_BW, 8'h80, 8'hff);
    rdchk("ctrl clear", pll_pkg::IDX_CTRL, 8'h20, 8'hbf);
    wr(pll_pkg::IDX_CTRL, 8'ha0);
    vco_half <= 4'h2;
    repeat (500) @(posedge clk_i);
    chk_reg("irq on lock", 8'h1, {7'h0, irq_o});
    rdchk("bw locked", pll_pkg::IDX_BW, 8'he0, 8'hff);
    chk_reg("acq locked", 8'h0, {7'h0, acq_mode_o});
    rdchk("ctrl flag", pll_pkg::IDX_CTRL, 8'he0, 8'hff);
    repeat (2) @(posedge clk_i);
    chk_reg("irq cleared", 8'h0, {7'h0, irq_o});
    // Slow then fast VCO: pump direction and loss of lock
    for (i = 0; i < 2; i++) begin
      vco_half <= (i == 0) ? 4'h4 : 4'h1;
      c = 0;
      t = 0;
      repeat (300) begin
        @(posedge clk_i);
        c += (pump_up_o === 1'h1) ? 1 : 0;
        t += (pump_down_o === 1'h1) ? 1 : 0;
      end
      chk_cnt("pump direction", 16'(1 - i), 16'(c > t));
      repeat (300) @(posedge clk_i);
      chk_reg("acq unlocked", 8'h1, {7'h0, acq_mode_o});
      rdchk("bw unlocked", pll_pkg::IDX_BW, 8'h80, 8'hff);
      rdchk("ctrl any", pll_pkg::IDX_CTRL, 8'ha0, 8'hbf);
    end
    vco_half <= 4'h2;
    repeat (500) @(posedge clk_i);
    chk_reg("irq relock", 8'h1, {7'h0, irq_o});
    rdchk("ctrl relock", pll_pkg::IDX_CTRL, 8'he0, 8'hff);
    // Manual bandwidth: tracking bit writable and drives the mode
    wr(pll_pkg::IDX_BW, 8'h00);
    wr(pll_pkg::IDX_BW, 8'h00);
    chk_reg("acq manual clear", 8'h1, {7'h0, acq_mode_o});
    wr(pll_pkg::IDX_BW, 8'h20);
    chk_reg("acq manual trk", 8'h0, {7'h0, acq_mode_o});
    rdchk("bw manual", pll_pkg::IDX_BW, 8'h20, 8'ha0);
    wr(pll_pkg::IDX_BW, 8'h00);
    chk_reg("acq manual", 8'h1, {7'h0, acq_mode_o});
    wr(pll_pkg::IDX_BW, 8'h80);
    repeat (300) @(posedge clk_i);
    // Base clock source change and interlocks
    gap(2, g);
    chk_cnt("crystal base", 16'd8, g);
    rdchk("bw before select", pll_pkg::IDX_BW, 8'he0, 8'hff);
    wr(pll_pkg::IDX_CTRL, 8'h30);
    c = 0;
    pb = base_clock_out_o;
    repeat (16) begin
      @(posedge clk_i);
      c += (base_clock_out_o !== pb) ? 1 : 0;
    end
    chk_cnt("switch hold", 16'h0, c[15:0]);
    gap(2, g);
    chk_cnt("vco base", 16'd4, g);
    wr(pll_pkg::IDX_CTRL, 8'h10);
    rdchk("off while sel", pll_pkg::IDX_CTRL, 8'h30, 8'hbf);
    wr(pll_pkg::IDX_CTRL, 8'h20);
    gap(2, g);
    chk_cnt("back to crystal", 16'd8, g);
    wr(pll_pkg::IDX_CTRL, 8'h10);
    rdchk("both at once", pll_pkg::IDX_CTRL, 8'h20, 8'hbf);
    wr(pll_pkg::IDX_CTRL, 8'h00);
    wr(pll_pkg::IDX_CTRL, 8'h10);
    rdchk("sel while off", pll_pkg::IDX_CTRL, 8'h00, 8'hbf);
    chk_reg("pll enable off", 8'h0, {7'h0, pll_enable_o});
    give_verdict();
  end
endmodule
`default_nettype wire
